//--- logic/fdcrr_map.svh
// register offsets, field positions and reset values of the rate and drive register group
`ifndef FDCRR_MAP_SVH
`define FDCRR_MAP_SVH

`define FDCRR_OFF_DOR        3'h2
`define FDCRR_OFF_TAPE       3'h3
`define FDCRR_OFF_MSR_RATE   3'h4
`define FDCRR_OFF_FIFO       3'h5
`define FDCRR_OFF_DIAG_CCR   3'h7

`define FDCRR_RATE_500K      2'h0
`define FDCRR_RATE_300K      2'h1
`define FDCRR_RATE_250K      2'h2
`define FDCRR_RATE_1M        2'h3
`define FDCRR_TAPE_2M        2'h2

`define FDCRR_PRE_DEFAULT    3'h0
`define FDCRR_PRE_OFF        3'h7
`define FDCRR_PRE_DEF_STEPS  3'h3
`define FDCRR_PRE_ONE_STEP   3'h1

`define FDCRR_DR_SWRST_BIT   7
`define FDCRR_DR_PDOWN_BIT   6
`define FDCRR_CC_NO_PRECOMP_FLAG_BIT  2
`define FDCRR_DOR_DMA_BIT    3
`define FDCRR_DR_PRE_MSB     4
`define FDCRR_DR_PRE_LSB     2

`define FDCRR_ST0_INVALID    2'h2
`define FDCRR_ST0_ABNORMAL   2'h3
`define FDCRR_ST0_IC_LSB     6

`define FDCRR_RATE_RESET     2'h2
`define FDCRR_BYTE_ZERO      8'h00
`define FDCRR_DIAG_ONES_PS   4'hF
`define FDCRR_DIAG_ONES_M30  3'h7
`define FDCRR_MSR_IDLE       8'h80
`define FDCRR_OE_NONE        8'hFF
`define FDCRR_OE_BIT7_ONLY   8'h7F

`endif

//--- logic/fdcrr_pkg.sv
// types shared by the rate and drive register group
package fdcrr_pkg;
   // host compatibility mode of the register views
   typedef enum logic [1:0] {
      FDCRR_MODE_AT  = 2'b00,
      FDCRR_MODE_PS  = 2'b01,
      FDCRR_MODE_M30 = 2'b10
   } fdcrr_mode_e;

   // data port phase
   typedef enum logic [1:0] {
      FDCRR_PH_CMD    = 2'b00,
      FDCRR_PH_RESULT = 2'b01
   } fdcrr_phase_e;
endpackage

//--- logic/fdcrr_regs.sv
// host register group of the floppy controller: tape, rate, data port, diagnostics
// Summary of operation
// - tape select 00 none, 01/10/11 drives 1-3; drive 0 never a tape
// - without three-mode, only tape register bits 1:0 carry meaning
// - extended tape layout only while three-mode enable is set
// - tape bits 7:6 read media id from config F1 bits 5,4
// - tape bits 5:4 give F2 drive type pair of last selected drive
// - tape bits 3:2 give boot drive from config F1 bits 7,6
// - offset 4 reads main status, writes rate; offset 7 diag/config control
// - rate in effect is from the last rate or config control write
// - rate register bit 7 written one triggers software reset
// - rate register bit 6 selects power-down when one
// - precomp 000 default, 001-110 steps, 111 disabled
// - default precomp 125 ns low rates, 41.67 at 1M, 20.8 at 2M
// - rate field selects speed; reduced write current high for 00 and 11
// - 2 Mbps tape rate only with rate 01 and tape rate bits 10
// - data port at offset 5 with four stacked status registers, one shown
// - fifo disabled after reset; only configure command enables it
// - status zero interrupt code 10 invalid, 11 ready changed
// - AT mode diag read drives only bit 7, inverted disk changed
// - second mode diag: 6-3 ones, 2:1 rate, bit 0 density
// - third mode diag: true changed, ones, dma, no-precomp, rate
// - third mode config control bit 2 stores no-precomp flag only
// - master reset clears the whole digital output register
`timescale 1ns/10ps
`default_nettype none
`include "fdcrr_map.svh"

module fdcrr_regs #(
   parameter logic [15:0] BASE_ADDR = 16'h03F0
) (
   input  wire logic                clk_i,
   input  wire logic                rstn_i,
   input  wire logic                master_reset_pin_i,
   input  wire logic [15:0]         addr_i,
   input  wire logic                rd_i,
   input  wire logic                wr_i,
   input  wire logic [7:0]          wdata_i,
   input  wire fdcrr_pkg::fdcrr_mode_e mode_i,
   input  wire logic                three_mode_enable_i,
   input  wire logic [7:0]          ldev0_config_reg_f_one_i,
   input  wire logic [7:0]          ldev0_config_reg_f_two_i,
   input  wire logic [1:0]          tape_rate_bits_i,
   input  wire logic                disk_changed_input_i,
   input  wire logic                cmd_invalid_i,
   input  wire logic                ready_changed_i,
   input  wire logic                configure_fifo_i,
   input  wire logic                configure_fifo_en_i,
   input  wire logic [7:0]          result_byte_i,
   input  wire logic                result_push_i,
   input  wire logic [7:0]          main_status_i,
   output logic [7:0]               rdata_o,
   output logic [7:0]               rdata_oe_n_o,
   output logic [1:0]               rate_select_field_o,
   output logic                     tape_2m_o,
   output logic                     reduced_write_current_o,
   output logic [2:0]               precomp_steps_o,
   output logic                     precomp_half_step_o,
   output logic                     power_down_o,
   output logic                     soft_reset_o,
   output logic                     fifo_enable_o,
   output logic [7:0]               digital_out_o,
   output logic [1:0]               tape_select_o,
   output logic                     cmd_strobe_o,
   output logic [7:0]               cmd_byte_o
);

   logic [1:0] rst_sync_r;
   logic       rst_n;
   logic       hit;
   logic [2:0] off;
   logic       wr_rate;
   logic       wr_ccr;
   logic       wr_dor;
   logic       wr_tape;
   logic       wr_fifo;
   logic       rd_fifo;
   logic [7:0] dor_r;
   logic [1:0] tape_sel_r;
   logic [1:0] rate_r;
   logic [2:0] precomp_r;
   logic       pdown_r;
   logic       no_precomp_flag_r;
   logic       fifo_en_r;
   logic [7:0] stat_stack_r [0:3];
   logic [1:0] stat_ptr_r;
   logic [1:0] stat_cnt_r;
   logic [1:0] drv_type;
   logic [7:0] tape_view;
   logic [7:0] diag_view;
   logic [7:0] diag_oe_n;
   logic [7:0] rd_nxt;
   logic [7:0] oe_n_nxt;
   logic       is_2m;
   logic [2:0] steps_nxt;

   // reset release through two flops, assertion stays asynchronous
   // a clean release keeps every flop of the group leaving reset on one edge
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   assign hit     = (addr_i[15:3] == BASE_ADDR[15:3]);
   assign off     = addr_i[2:0];
   assign wr_rate = wr_i && hit && (off == `FDCRR_OFF_MSR_RATE);
   assign wr_ccr  = wr_i && hit && (off == `FDCRR_OFF_DIAG_CCR);
   // remaining strobes; a stray host read of the data port costs a status byte
   assign wr_dor  = wr_i && hit && (off == `FDCRR_OFF_DOR);
   assign wr_tape = wr_i && hit && (off == `FDCRR_OFF_TAPE);
   assign wr_fifo = wr_i && hit && (off == `FDCRR_OFF_FIFO);
   assign rd_fifo = rd_i && hit && (off == `FDCRR_OFF_FIFO);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dor_r <= `FDCRR_BYTE_ZERO;
      end else if (master_reset_pin_i) begin
         dor_r <= `FDCRR_BYTE_ZERO;
      end else if (wr_dor) begin
         dor_r <= wdata_i;
      end
   end

   // tape drive assignment, code 00 means none
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tape_sel_r <= 2'h0;
      end else if (wr_tape) begin
         tape_sel_r <= wdata_i[1:0];
      end
   end

   // last of rate or config write wins
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rate_r <= `FDCRR_RATE_RESET;
      end else if (wr_rate || wr_ccr) begin
         rate_r <= wdata_i[1:0];
      end
   end

   // power-down and precomp held from rate writes
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pdown_r   <= 1'b0;
         precomp_r <= `FDCRR_PRE_DEFAULT;
      end else if (wr_rate) begin
         pdown_r   <= wdata_i[`FDCRR_DR_PDOWN_BIT];
         precomp_r <= wdata_i[`FDCRR_DR_PRE_MSB:`FDCRR_DR_PRE_LSB];
      end
   end

   // no-precomp flag stored only, no effect on delay
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         no_precomp_flag_r <= 1'b0;
      end else if (wr_ccr && mode_i == fdcrr_pkg::FDCRR_MODE_M30) begin
         no_precomp_flag_r <= wdata_i[`FDCRR_CC_NO_PRECOMP_FLAG_BIT];
      end
   end

   // one-cycle software reset pulse
   // rate and precomp survive it; only the fifo setting is dropped
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         soft_reset_o <= 1'b0;
      end else begin
         soft_reset_o <= wr_rate && wdata_i[`FDCRR_DR_SWRST_BIT];
      end
   end

   // fifo off after reset; configure command sets it, software reset pulse clears it
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fifo_en_r <= 1'b0;
      end else if (soft_reset_o) begin
         fifo_en_r <= 1'b0;
      end else if (configure_fifo_i) begin
         fifo_en_r <= configure_fifo_en_i;
      end
   end

   // four stacked result registers, read pointer walks the stack
   // status zero interrupt code forced for invalid or ready change
   // invalid beats ready change; a push restarts the read pointer
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            stat_stack_r[i] <= `FDCRR_BYTE_ZERO;
         end
         stat_cnt_r <= 2'h0;
         stat_ptr_r <= 2'h0;
      end else if (cmd_invalid_i || ready_changed_i) begin
         stat_stack_r[0] <= {cmd_invalid_i ? `FDCRR_ST0_INVALID : `FDCRR_ST0_ABNORMAL,
                             result_byte_i[`FDCRR_ST0_IC_LSB-1:0]};
         stat_cnt_r      <= 2'h0;
         stat_ptr_r      <= 2'h0;
      end else if (result_push_i) begin
         stat_stack_r[stat_cnt_r] <= result_byte_i;
         stat_cnt_r               <= stat_cnt_r + 2'h1;
         stat_ptr_r               <= 2'h0;
      end else if (rd_fifo) begin
         stat_ptr_r <= stat_ptr_r + 2'h1;
      end
   end

   // drive type pair for last selected drive
   // select bits of the digital output pick which pair is shown
   always_comb begin
      unique case (dor_r[1:0])
         2'h0: drv_type = ldev0_config_reg_f_two_i[1:0];
         2'h1: drv_type = ldev0_config_reg_f_two_i[3:2];
         2'h2: drv_type = ldev0_config_reg_f_two_i[5:4];
         2'h3: drv_type = ldev0_config_reg_f_two_i[7:6];
      endcase
   end

   // plain layout unless three-mode; media and boot
   always_comb begin
      tape_view = {6'h00, tape_sel_r};
      if (three_mode_enable_i) begin
         tape_view = {ldev0_config_reg_f_one_i[5], ldev0_config_reg_f_one_i[4],
                      drv_type,
                      ldev0_config_reg_f_one_i[7], ldev0_config_reg_f_one_i[6],
                      tape_sel_r};
      end
   end

   always_comb begin
      diag_oe_n = `FDCRR_BYTE_ZERO;
      unique case (mode_i)
         fdcrr_pkg::FDCRR_MODE_PS: begin
            diag_view = {~disk_changed_input_i, `FDCRR_DIAG_ONES_PS, rate_r,
                         (rate_r == `FDCRR_RATE_300K || rate_r == `FDCRR_RATE_250K)};
         end
         fdcrr_pkg::FDCRR_MODE_M30: begin
            diag_view = {disk_changed_input_i, `FDCRR_DIAG_ONES_M30,
                         dor_r[`FDCRR_DOR_DMA_BIT], no_precomp_flag_r, rate_r};
         end
         default: begin
            diag_view = {~disk_changed_input_i, 7'h00};
            diag_oe_n = `FDCRR_OE_BIT7_ONLY;
         end
      endcase
   end

   // read mux; undriven bits show through oe_n high
   // offsets not owned by this group leave the bus released
   always_comb begin
      rd_nxt   = `FDCRR_BYTE_ZERO;
      oe_n_nxt = `FDCRR_OE_NONE;
      if (rd_i && hit) begin
         oe_n_nxt = `FDCRR_BYTE_ZERO;
         case (off)
            `FDCRR_OFF_TAPE:     rd_nxt = tape_view;
            `FDCRR_OFF_MSR_RATE: rd_nxt = main_status_i;
            `FDCRR_OFF_FIFO:     rd_nxt = stat_stack_r[stat_ptr_r];
            `FDCRR_OFF_DIAG_CCR: begin
               rd_nxt   = diag_view;
               oe_n_nxt = diag_oe_n;
            end
            default:             oe_n_nxt = `FDCRR_OE_NONE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o      <= `FDCRR_BYTE_ZERO;
         rdata_oe_n_o <= `FDCRR_OE_NONE;
      end else begin
         rdata_o      <= rd_nxt;
         rdata_oe_n_o <= oe_n_nxt;
      end
   end

   // tape 2M needs rate 01 and tape rate bits 10
   // tape rate bits are config levels, not latched here
   assign is_2m = (rate_r == `FDCRR_RATE_300K) && (tape_rate_bits_i == `FDCRR_TAPE_2M);

   // steps of 41.67 ns, half steps at 2M; default per rate
   always_comb begin
      if (precomp_r == `FDCRR_PRE_OFF) begin
         steps_nxt = 3'h0;
      end else if (precomp_r != `FDCRR_PRE_DEFAULT) begin
         steps_nxt = precomp_r;
      end else if (is_2m || rate_r == `FDCRR_RATE_1M) begin
         steps_nxt = `FDCRR_PRE_ONE_STEP;
      end else begin
         steps_nxt = `FDCRR_PRE_DEF_STEPS;
      end
   end

   // rate outputs and reduced write current
   // every output of this block is a flop fed from registers, tape 2M and precomp also from tape_rate_bits_i; a write shows one edge after it is taken
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rate_select_field_o     <= `FDCRR_RATE_RESET;
         tape_2m_o               <= 1'b0;
         reduced_write_current_o <= 1'b0;
         precomp_steps_o         <= 3'h0;
         precomp_half_step_o     <= 1'b0;
         power_down_o            <= 1'b0;
         fifo_enable_o           <= 1'b0;
         digital_out_o           <= `FDCRR_BYTE_ZERO;
         tape_select_o           <= 2'h0;
      end else begin
         rate_select_field_o     <= rate_r;
         tape_2m_o               <= is_2m;
         reduced_write_current_o <= (rate_r == `FDCRR_RATE_500K) || (rate_r == `FDCRR_RATE_1M);
         precomp_steps_o         <= steps_nxt;
         precomp_half_step_o     <= is_2m;
         power_down_o            <= pdown_r;
         fifo_enable_o           <= fifo_en_r;
         digital_out_o           <= dor_r;
         tape_select_o           <= tape_sel_r;
      end
   end

   // command bytes written to the data port go to the engine
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cmd_strobe_o <= 1'b0;
         cmd_byte_o   <= `FDCRR_BYTE_ZERO;
      end else begin
         cmd_strobe_o <= wr_fifo;
         cmd_byte_o   <= wdata_i;
      end
   end

endmodule // fdcrr_regs
`default_nettype wire

//--- test/fdcrr_regs_assertions.sv
// protocol checker of the rate and drive register group
`timescale 1ns/10ps
`default_nettype none
module fdcrr_regs_chk #(
   parameter logic [15:0] BASE_ADDR = 16'h03F0
) (
   input wire logic                   clk_i,
   input wire logic                   rstn_i,
   input wire logic                   master_reset_pin_i,
   input wire logic [15:0]            addr_i,
   input wire logic                   rd_i,
   input wire logic                   wr_i,
   input wire logic [7:0]             wdata_i,
   input wire fdcrr_pkg::fdcrr_mode_e mode_i,
   input wire logic                   disk_changed_input_i,
   input wire logic [7:0]             main_status_i,
   input wire logic [7:0]             rdata_o,
   input wire logic [7:0]             rdata_oe_n_o,
   input wire logic [1:0]             rate_select_field_o,
   input wire logic                   reduced_write_current_o,
   input wire logic                   soft_reset_o,
   input wire logic [7:0]             digital_out_o,
   input wire logic                   cmd_strobe_o,
   input wire logic [7:0]             cmd_byte_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // block hit and offset, shared by the properties
   wire logic       hit = (addr_i[15:3] == BASE_ADDR[15:3]);
   wire logic [2:0] off = addr_i[2:0];
   a_bus_idle_float: assert property (!$past(rd_i) |-> rdata_oe_n_o == 8'hFF)
      else $error("bus driven without a read");
   a_at_diag_bit: assert property ($past(rd_i && hit && off == 3'h7) &&
      $past(mode_i == fdcrr_pkg::FDCRR_MODE_AT) |-> rdata_oe_n_o == 8'h7F &&
      rdata_o[7] == !$past(disk_changed_input_i))
      else $error("diag read in first mode wrong");
   a_status_read: assert property ($past(rd_i && hit && off == 3'h4) |->
      rdata_o == $past(main_status_i) && rdata_oe_n_o == 8'h00) else $error("status read");
   a_miss_no_drive: assert property ($past(rd_i && !hit) |-> rdata_oe_n_o == 8'hFF)
      else $error("foreign address answered");
   a_rwc_follows: assert property (reduced_write_current_o ==
      (rate_select_field_o[1] ~^ rate_select_field_o[0])) else $error("write current");
   a_rate_last_wr: assert property (wr_i && hit && (off == 3'h4 || off == 3'h7) &&
      !wdata_i[7] ##1 !wr_i |=> rate_select_field_o == $past(wdata_i[1:0], 2))
      else $error("rate not taken from last write");
   a_soft_rst_fire: assert property (wr_i && hit && off == 3'h4 && wdata_i[7] |->
      ##[1:2] soft_reset_o) else $error("no software reset pulse");
   a_port_strobe: assert property (wr_i && hit && off == 3'h5 |=> cmd_strobe_o &&
      cmd_byte_o == $past(wdata_i)) else $error("data port write lost");
   a_mreset_clear: assert property (master_reset_pin_i [*2] |=>
      digital_out_o == 8'h00) else $error("output register not cleared");
endmodule // fdcrr_regs_chk

bind fdcrr_regs fdcrr_regs_chk #(.BASE_ADDR(BASE_ADDR)) u_chk (
   .clk_i, .rstn_i, .master_reset_pin_i, .addr_i, .rd_i, .wr_i, .wdata_i, .mode_i,
   .disk_changed_input_i, .main_status_i, .rdata_o, .rdata_oe_n_o, .rate_select_field_o,
   .reduced_write_current_o, .soft_reset_o, .digital_out_o, .cmd_strobe_o, .cmd_byte_o
);
`default_nettype wire

//--- test/fdcrr_host_model.sv
// host processor model driving the parallel register bus
`timescale 1ns/10ps
`default_nettype none
module fdcrr_host_model (
   input  wire logic        clk_i,
   output logic [15:0]      addr_o,
   output logic             rd_o,
   output logic             wr_o,
   output logic [7:0]       wdata_o
);
   // bus parked idle from time zero
   initial begin
      addr_o = 16'h0000;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 8'h00;
   end
   // one access: held across the taking edge, then lines flipped so stale values never match
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      rd_o = !w;
      wr_o = w;
      @(negedge clk_i);
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
endmodule // fdcrr_host_model
`default_nettype wire

//--- test/tb_fdc_rate_and_drive_registers.sv
// self-checking bench of the rate and drive register group
`timescale 1ns/10ps
`default_nettype none
module tb_fdc_rate_and_drive_registers;
   localparam logic [15:0] B = 16'h03F0;
   logic                   clk_i, rstn_i, mr, tme, dsk, cfg, cfg_en, rd, wr;
   logic                   t2m, reduced_write_current, half, pdn, fen;
   logic                   srst, cstb, push, bad_cmd, ready_chg;
   logic [1:0]             trb, rate, tsel;
   logic [2:0]             steps;
   logic [7:0]             f1, f2, msr, wd, rdata, oe_n, dout, cbyte, rbyte;
   logic [15:0]            addr;
   fdcrr_pkg::fdcrr_mode_e mode;
   int                     bad_count, tests_run;

   fdcrr_host_model hm (.clk_i, .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
   fdcrr_regs dut_u (
      .clk_i, .rstn_i, .master_reset_pin_i(mr), .addr_i(addr), .rd_i(rd), .wr_i(wr),
      .wdata_i(wd), .mode_i(mode), .three_mode_enable_i(tme),
      .ldev0_config_reg_f_one_i(f1), .ldev0_config_reg_f_two_i(f2),
      .tape_rate_bits_i(trb), .disk_changed_input_i(dsk), .cmd_invalid_i(bad_cmd),
      .ready_changed_i(ready_chg), .configure_fifo_i(cfg), .configure_fifo_en_i(cfg_en),
      .result_byte_i(rbyte), .result_push_i(push), .main_status_i(msr),
      .rdata_o(rdata), .rdata_oe_n_o(oe_n), .rate_select_field_o(rate), .tape_2m_o(t2m),
      .reduced_write_current_o(reduced_write_current), .precomp_steps_o(steps), .precomp_half_step_o(half),
      .power_down_o(pdn), .soft_reset_o(srst), .fifo_enable_o(fen), .digital_out_o(dout),
      .tape_select_o(tsel), .cmd_strobe_o(cstb), .cmd_byte_o(cbyte)
   );
   // compare and count
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // write, then wait for the effect to reach the outputs
   task automatic wrr(input logic [2:0] o, input logic [7:0] d);
      hm.xfer(1'b1, {B[15:3], o}, d);
      @(negedge clk_i);
   endtask
   // read data stands right after the access
   task automatic rdr(input logic [2:0] o);
      hm.xfer(1'b0, {B[15:3], o}, 8'h00);
   endtask
   task automatic t_reset();
      chk("fifo enable", fen, 8'h00);
      chk("rate", rate, 8'h02);
      chk("digital out", dout, 8'h00);
   endtask
   task automatic t_rates();
      for (int r = 0; r < 4; r++) begin
         wrr(3'h4, 8'(r));
         chk("rate", rate, 8'(r));
         chk("rwc", reduced_write_current, 8'(r == 0 || r == 3));
         chk("precomp", steps, (r == 3) ? 8'h01 : 8'h03);
         // reserved config bits kept zero
         wrr(3'h7, 8'(r ^ 1));
         chk("rate", rate, 8'(r ^ 1));
      end
   endtask
   task automatic t_precomp();
      trb = 2'h2;
      wrr(3'h4, 8'h01);
      chk("tape 2m", t2m, 8'h01);
      chk("half step", half, 8'h01);
      chk("precomp", steps, 8'h01);
      wrr(3'h4, 8'h15);
      chk("precomp", steps, 8'h05);
      trb = 2'h1;
      wrr(3'h4, 8'h1D);
      chk("tape 2m", t2m, 8'h00);
      chk("precomp", steps, 8'h00);
   endtask
   task automatic t_ctrl();
      wrr(3'h4, 8'h42);
      chk("power down", pdn, 8'h01);
      // only the configure command turns the fifo on
      cfg = 1'b1;
      cfg_en = 1'b1;
      @(negedge clk_i);
      cfg = 1'b0;
      @(negedge clk_i);
      chk("fifo enable", fen, 8'h01);
      // strobe and byte stand only in the cycle after the write
      hm.xfer(1'b1, {B[15:3], 3'h5}, 8'h03);
      chk("command strobe", cstb, 8'h01);
      chk("command byte", cbyte, 8'h03);
      hm.xfer(1'b1, {B[15:3], 3'h4}, 8'h82);
      chk("soft reset", srst, 8'h01);
      repeat (2) @(negedge clk_i);
      chk("soft reset", srst, 8'h00);
      chk("fifo enable", fen, 8'h00);
      chk("power down", pdn, 8'h00);
      rdr(3'h4);
      chk("status", rdata, msr);
   endtask
   task automatic t_diag();
      rdr(3'h7);
      chk("diag enables", oe_n, 8'h7F);
      chk("diag bit7", rdata[7], 8'h00);
      mode = fdcrr_pkg::FDCRR_MODE_PS;
      for (int r = 0; r < 2; r++) begin
         wrr(3'h7, 8'(r));
         rdr(3'h7);
         chk("diag", rdata, 8'h78 | 8'(r * 3));
      end
      chk("diag enables", oe_n, 8'h00);
      mode = fdcrr_pkg::FDCRR_MODE_M30;
      wrr(3'h2, 8'h08);
      wrr(3'h7, 8'h06);
      rdr(3'h7);
      chk("diag", rdata, 8'hFE);
      chk("precomp", steps, 8'h03);
      mode = fdcrr_pkg::FDCRR_MODE_AT;
   endtask
   task automatic t_tape();
      for (int t = 0; t < 4; t++) begin
         wrr(3'h3, 8'(t));
         chk("tape select", tsel, 8'(t));
      end
      rdr(3'h3);
      chk("tape bits", rdata[1:0], 8'h03);
      tme = 1'b1;
      wrr(3'h2, 8'h01);
      rdr(3'h3);
      chk("tape info", rdata, 8'hFB);
      wrr(3'h2, 8'h02);
      rdr(3'h3);
      chk("tape info", rdata, 8'hCB);
      tme = 1'b0;
   endtask
   task automatic t_decode();
      chk("digital out", dout, 8'h02);
      mr = 1'b1;
      repeat (2) @(negedge clk_i);
      mr = 1'b0;
      @(negedge clk_i);
      chk("digital out", dout, 8'h00);
      rdr(3'h6);
      chk("unmapped", oe_n, 8'hFF);
      hm.xfer(1'b0, 16'h0377, 8'h00);
      chk("foreign read", oe_n, 8'hFF);
      hm.xfer(1'b1, 16'h0374, 8'h03);
      @(negedge clk_i);
      chk("rate", rate, 8'h02);
   endtask
   task automatic t_result();
      for (int i = 0; i < 4; i++) begin
         rbyte = 8'(8'h11 * (i + 1));
         push = 1'b1;
         @(negedge clk_i);
      end
      push = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rdr(3'h5);
         chk("result stack", rdata, 8'(8'h11 * (i + 1)));
      end
      rbyte = 8'h05;
      ready_chg = 1'b1;
      @(negedge clk_i);
      ready_chg = 1'b0;
      rdr(3'h5);
      chk("status zero", rdata, 8'hC5);
      // both events at once: invalid command code wins
      {bad_cmd, ready_chg} = 2'h3;
      @(negedge clk_i);
      {bad_cmd, ready_chg} = 2'h0;
      rdr(3'h5);
      chk("status zero", rdata, 8'h85);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // hang guard, counted as a mismatch
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
   initial begin
      {rstn_i, mr, tme, dsk, cfg, cfg_en, trb} = 8'h10;
      {push, bad_cmd, ready_chg, rbyte} = 11'h000;
      f1 = 8'hB0;
      f2 = 8'h0C;
      msr = 8'h5A;
      mode = fdcrr_pkg::FDCRR_MODE_AT;
      bad_count = 0;
      tests_run = 0;
      repeat (2) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (2) @(negedge clk_i);
      t_reset();
      t_rates();
      t_precomp();
      t_ctrl();
      t_diag();
      t_tape();
      t_result();
      t_decode();
      final_report();
   end
endmodule // tb_fdc_rate_and_drive_registers
`default_nettype wire
